//--- verilog/timer3_pkg.sv
// constants for the timer 3 block: register map, fields, tick rates
// assumes a 200 MHz system clock and byte addresses of four times the index
`default_nettype none
package timer3_pkg;
  // ************************************************************
  // register indices, byte address is four times the index
  // ************************************************************
  localparam logic [7:0] IDX_T2_LIVE_LOW = 8'h1D;
  localparam logic [7:0] IDX_CONTROL = 8'h1E;
  localparam logic [7:0] IDX_RELOAD_HIGH = 8'h1F;
  localparam logic [7:0] IDX_RELOAD_LOW = 8'h20;
  localparam logic [7:0] IDX_LIVE_HIGH = 8'h21;
  localparam logic [7:0] IDX_LIVE_LOW = 8'h22;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
  localparam logic [7:0] IDX_COMMAND = 8'h32;
  localparam int ADDR_W = 10;
  // ************************************************************
  // control fields
  // ************************************************************
  localparam int BIT_STOP_RX = 7;
  localparam int BIT_START_HI = 5;
  localparam int BIT_START_LO = 4;
  localparam int BIT_RELOAD = 3;
  localparam int BIT_TICK_HI = 1;
  localparam int BIT_TICK_LO = 0;
  localparam logic [7:0] CONTROL_WMASK = 8'hBB;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [1:0] START_NONE = 2'h0;
  localparam logic [1:0] START_TX_END = 2'h1;
  localparam logic [1:0] START_TRIM_NOUF = 2'h2;
  localparam logic [1:0] START_TRIM_UF = 2'h3;
  localparam logic [1:0] TICK_CARRIER = 2'h0;
  localparam logic [1:0] TICK_SLOW = 2'h1;
  localparam logic [1:0] TICK_T0_UF = 2'h2;
  localparam logic [1:0] TICK_T1_UF = 2'h3;
  localparam int BIT_CMD_START = 0;
  localparam int BIT_CMD_STOP = 1;
  localparam int BIT_IRQ_UF = 0;
  // ************************************************************
  // tick rates
  // ************************************************************
  localparam int CLK_KHZ = 200000;
  localparam int CARRIER_KHZ = 13560;
  localparam int SLOW_TICK_HZ = 211875;
  localparam int SLOW_DIV = (CARRIER_KHZ * 1000) / SLOW_TICK_HZ;
  localparam int ACC_W = 18;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(CARRIER_KHZ);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_KHZ);
  localparam logic [5:0] SLOW_LAST = 6'(SLOW_DIV - 1);
  // ************************************************************
  // bus answers
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- verilog/reader_timer3_control.sv
// timer 3 of the reader core: 16-bit down-counter, AXI4-Lite registers
// assumes event inputs come from logic on aclk; the oscillator input is asynchronous
// What this block does
// R1: timer 2 live count low byte readable, read-only, at index 1Dh.
// R2: software avoids reading live counts while a frame is received.
// R3: control holds stop-on-rx bit7, start bits5:4, reload bit3, tick bits1:0.
// R4: stop-on-rx set halts timer after first four received bits.
// R5: in trimming start modes the stop-on-rx bit does nothing.
// R6: start 00b no automatic start; 01b starts at end of transmission.
// R7: start 10b/11b trimming without/with underflow, start and stop on rising edge.
// R8: reload bit set reloads the value and keeps counting at underflow.
// R9: reload bit clear counts to zero then stops until restarted.
// R10: every underflow sets the underflow interrupt flag.
// R11: tick 00b runs at the carrier rate, 01b at carrier over 64.
// R12: tick 10b counts timer 0 underflows, 11b timer 1 underflows.
// R13: reload value split in high and low byte registers, writable.
// R14: start loads high and low reload bytes; writes wait for next start, or for the next underflow when the reload bit is set.
// R15: timer 3 live count readable as high and low bytes from 21h.
// R16: one decrement per tick; underflow on the tick leaving zero.
// R17: reserved control bits read zero, writes to them ignored.
`timescale 1ns/1ps
`default_nettype none
module reader_timer3_control (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [timer3_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [timer3_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // core events, one-cycle pulses on aclk, and the timer 2 live count
  input wire logic tx_end,
  input wire logic rx_first_nibble,
  input wire logic timer0_underflow,
  input wire logic timer1_underflow,
  input wire logic [15:0] timer2_count,
  // asynchronous oscillator level
  input wire logic low_freq_oscillator,
  // interrupt
  output logic irq
);
  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] control_r;
  logic [7:0] reload_high_r;
  logic [7:0] reload_low_r;
  logic [7:0] irq_status_r;
  logic [7:0] irq_mask_r;
  logic [15:0] count_r;
  logic running_r;
  logic [timer3_pkg::ACC_W-1:0] acc_r;
  logic [5:0] slow_cnt_r;
  logic lfo_s1_r;
  logic lfo_s2_r;
  logic lfo_prev_r;
  logic aw_have_r;
  logic w_have_r;
  logic [7:0] aw_idx_r;
  logic [7:0] w_byte_r;
  logic w_lane0_r;

  // ************************************************************
  // tick generation
  // ************************************************************
  // phase accumulator keeps the long-run carrier rate exact at 200 MHz
  logic [timer3_pkg::ACC_W-1:0] acc_sum;
  logic carrier_tick;
  logic slow_tick;
  logic tick;
  logic [1:0] tick_sel;
  assign acc_sum = acc_r + timer3_pkg::ACC_STEP;
  assign carrier_tick = acc_sum >= timer3_pkg::ACC_WRAP;
  assign slow_tick = carrier_tick && (slow_cnt_r == timer3_pkg::SLOW_LAST);
  assign tick_sel = control_r[timer3_pkg::BIT_TICK_HI:timer3_pkg::BIT_TICK_LO];
  assign tick = (tick_sel == timer3_pkg::TICK_CARRIER) ? carrier_tick : // R11
                (tick_sel == timer3_pkg::TICK_SLOW) ? slow_tick : // R11
                (tick_sel == timer3_pkg::TICK_T0_UF) ? timer0_underflow : // R12
                timer1_underflow; // R12

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= '0;
      slow_cnt_r <= '0;
    end else if (ce) begin
      acc_r <= carrier_tick ? acc_sum - timer3_pkg::ACC_WRAP : acc_sum;
      if (carrier_tick) begin
        slow_cnt_r <= slow_tick ? 6'h00 : slow_cnt_r + 6'h01;
      end
    end
  end

  // ************************************************************
  // oscillator edge
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfo_s1_r <= 1'b0;
      lfo_s2_r <= 1'b0;
      lfo_prev_r <= 1'b0;
    end else if (ce) begin
      lfo_s1_r <= low_freq_oscillator;
      lfo_s2_r <= lfo_s1_r;
      lfo_prev_r <= lfo_s2_r;
    end
  end

  // ************************************************************
  // bus decode
  // ************************************************************
  logic aw_take;
  logic w_take;
  logic wr_do;
  logic ar_take;
  logic [7:0] ar_idx;
  logic wr_mapped;
  logic rd_mapped;
  logic [7:0] rd_byte;
  logic status_clear;
  logic cmd_start;
  logic cmd_stop;
  // ce low also holds the ready flags, so keep the bus idle while frozen
  assign aw_take = awvalid && awready;
  assign w_take = wvalid && wready;
  assign wr_do = aw_have_r && w_have_r && !bvalid;
  assign ar_take = arvalid && arready;
  assign ar_idx = araddr[timer3_pkg::ADDR_W-1:2];
  assign wr_mapped = (aw_idx_r == timer3_pkg::IDX_CONTROL) || (aw_idx_r == timer3_pkg::IDX_RELOAD_HIGH) ||
                     (aw_idx_r == timer3_pkg::IDX_RELOAD_LOW) || (aw_idx_r == timer3_pkg::IDX_IRQ_MASK) ||
                     (aw_idx_r == timer3_pkg::IDX_COMMAND);
  assign rd_mapped = (ar_idx >= timer3_pkg::IDX_T2_LIVE_LOW && ar_idx <= timer3_pkg::IDX_LIVE_LOW) ||
                     (ar_idx >= timer3_pkg::IDX_IRQ_STATUS && ar_idx <= timer3_pkg::IDX_COMMAND);
  // live counts are sampled as they stand; mid-frame values may be torn
  assign rd_byte = (ar_idx == timer3_pkg::IDX_T2_LIVE_LOW) ? timer2_count[7:0] : // R1 R2
                   (ar_idx == timer3_pkg::IDX_CONTROL) ? control_r : // R17
                   (ar_idx == timer3_pkg::IDX_RELOAD_HIGH) ? reload_high_r :
                   (ar_idx == timer3_pkg::IDX_RELOAD_LOW) ? reload_low_r :
                   (ar_idx == timer3_pkg::IDX_LIVE_HIGH) ? count_r[15:8] : // R15
                   (ar_idx == timer3_pkg::IDX_LIVE_LOW) ? count_r[7:0] : // R15
                   (ar_idx == timer3_pkg::IDX_IRQ_STATUS) ? irq_status_r :
                   (ar_idx == timer3_pkg::IDX_IRQ_MASK) ? irq_mask_r : 8'h00;
  assign status_clear = ce && ar_take && (ar_idx == timer3_pkg::IDX_IRQ_STATUS);
  assign cmd_start = wr_do && w_lane0_r && (aw_idx_r == timer3_pkg::IDX_COMMAND) &&
                     w_byte_r[timer3_pkg::BIT_CMD_START];
  assign cmd_stop = wr_do && w_lane0_r && (aw_idx_r == timer3_pkg::IDX_COMMAND) &&
                    w_byte_r[timer3_pkg::BIT_CMD_STOP];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_idx_r <= 8'h00;
      w_byte_r <= 8'h00;
      w_lane0_r <= 1'b0;
      bvalid <= 1'b0;
      bresp <= timer3_pkg::RESP_OKAY;
    end else if (ce) begin
      awready <= !aw_have_r && !aw_take && !bvalid;
      wready <= !w_have_r && !w_take && !bvalid;
      if (aw_take) begin
        aw_have_r <= 1'b1;
        aw_idx_r <= awaddr[timer3_pkg::ADDR_W-1:2];
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        w_byte_r <= wdata[7:0];
        w_lane0_r <= wstrb[0];
      end
      if (wr_do) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_mapped ? timer3_pkg::RESP_OKAY : timer3_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= timer3_pkg::RESP_OKAY;
    end else if (ce) begin
      arready <= !rvalid && !ar_take;
      if (ar_take) begin
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, rd_byte};
        rresp <= rd_mapped ? timer3_pkg::RESP_OKAY : timer3_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // software registers
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_r <= timer3_pkg::CONTROL_RESET;
      reload_high_r <= timer3_pkg::RELOAD_RESET;
      reload_low_r <= timer3_pkg::RELOAD_RESET;
      irq_mask_r <= 8'h00;
    end else if (ce && wr_do && w_lane0_r) begin
      case (aw_idx_r)
        timer3_pkg::IDX_CONTROL: control_r <= w_byte_r & timer3_pkg::CONTROL_WMASK; // R3 R17
        timer3_pkg::IDX_RELOAD_HIGH: reload_high_r <= w_byte_r; // R13
        timer3_pkg::IDX_RELOAD_LOW: reload_low_r <= w_byte_r; // R13
        timer3_pkg::IDX_IRQ_MASK: irq_mask_r <= w_byte_r;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // counter
  // ************************************************************
  logic [1:0] start_mode;
  logic trim_mode;
  logic lfo_rise;
  logic rx_stop;
  logic start_evt;
  logic stop_evt;
  logic uf_now;
  logic [15:0] reload_value;
  assign start_mode = control_r[timer3_pkg::BIT_START_HI:timer3_pkg::BIT_START_LO];
  assign trim_mode = start_mode[1]; // R7
  assign lfo_rise = lfo_s2_r && !lfo_prev_r;
  assign reload_value = {reload_high_r, reload_low_r}; // R14
  assign rx_stop = control_r[timer3_pkg::BIT_STOP_RX] && !trim_mode && rx_first_nibble; // R4 R5
  // the oscillator edge toggles the run state while trimming
  assign start_evt = cmd_start || ((start_mode == timer3_pkg::START_TX_END) && tx_end) || // R6
                     (trim_mode && lfo_rise && !running_r); // R7
  assign stop_evt = cmd_stop || rx_stop || (trim_mode && lfo_rise && running_r); // R4 R7
  // trimming without underflow simply parks at zero
  assign uf_now = running_r && tick && (count_r == 16'h0000) &&
                  (start_mode != timer3_pkg::START_TRIM_NOUF); // R7 R16

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= 16'h0000;
      running_r <= 1'b0;
    end else if (ce) begin
      if (stop_evt) begin
        running_r <= 1'b0; // R4
      end else if (start_evt) begin
        running_r <= 1'b1;
        count_r <= reload_value; // R14
      end else if (uf_now) begin
        if (control_r[timer3_pkg::BIT_RELOAD]) begin
          count_r <= reload_value; // R8
        end else begin
          running_r <= 1'b0; // R9
        end
      end else if (running_r && tick && (count_r != 16'h0000)) begin
        count_r <= count_r - 16'h0001; // R16
      end
    end
  end

  // ************************************************************
  // interrupt
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_r <= 8'h00;
      irq <= 1'b0;
    end else if (ce) begin
      // the set wins over a clearing read in the same cycle
      irq_status_r[timer3_pkg::BIT_IRQ_UF] <= uf_now || (irq_status_r[timer3_pkg::BIT_IRQ_UF] && !status_clear); // R10
      irq <= |(irq_status_r & irq_mask_r);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_t2_low_read: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    (ce && ar_take && ar_idx == timer3_pkg::IDX_T2_LIVE_LOW) |=> (rdata[7:0] == $past(timer2_count[7:0])))
    else $error("timer 2 low byte readback wrong");
  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn) // R17
    (control_r[6] == 1'b0) && (control_r[2] == 1'b0))
    else $error("reserved control bit set");
  a_rx_stop_halts: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    (ce && running_r && control_r[7] && !trim_mode && rx_first_nibble) |=> !running_r)
    else $error("receive did not stop timer");
  a_trim_ignores_rx: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    (ce && running_r && trim_mode && rx_first_nibble && !lfo_rise && !cmd_stop && !uf_now) |=> running_r)
    else $error("receive stopped trimming timer");
  a_tx_end_start: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    (ce && start_mode == timer3_pkg::START_TX_END && tx_end && !stop_evt)
    |=> (running_r && count_r == $past(reload_value)))
    else $error("end of transmission did not start timer");
  a_auto_reload: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    (ce && uf_now && control_r[3] && !stop_evt && !start_evt) |=> (running_r && count_r == $past(reload_value)))
    else $error("auto restart did not reload");
  a_one_shot_stop: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    (ce && uf_now && !control_r[3] && !start_evt) |=> !running_r)
    else $error("one shot timer kept running");
  a_underflow_flag: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    (ce && uf_now) |=> irq_status_r[0])
    else $error("underflow flag not set");
  a_single_decrement: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    (ce && running_r && tick && count_r != 16'h0000 && !start_evt && !stop_evt)
    |=> (count_r == $past(count_r) - 16'h0001))
    else $error("count did not drop by one");
  a_start_loads: assert property (@(posedge aclk) disable iff (!aresetn) // R14
    (ce && start_evt && !stop_evt) |=> (running_r && count_r == $past(reload_value)))
    else $error("start did not load reload value");
  a_live_high_read: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    (ce && ar_take && ar_idx == timer3_pkg::IDX_LIVE_HIGH) |=> (rdata[7:0] == $past(count_r[15:8])))
    else $error("timer 3 high byte readback wrong");
  a_no_tick_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    (ce && running_r && tick_sel == timer3_pkg::TICK_T0_UF && !timer0_underflow && !start_evt)
    |=> $stable(count_r))
    else $error("count moved without a tick");
  a_trim_parks: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    (ce && running_r && start_mode == timer3_pkg::START_TRIM_NOUF && count_r == 16'h0000 && !start_evt)
    |=> (count_r == 16'h0000))
    else $error("trimming count left zero");
endmodule
`default_nettype wire

//--- bench/reader_timer3_control_bench.sv
// bench for the timer 3 block: register rows, then counter cases
// assumes the design package and module are compiled first
`timescale 1ns/1ps
`default_nettype none
module reader_timer3_control_bench;
  // ********
  // signals
  // ********
  localparam logic [7:0] CTL = timer3_pkg::IDX_CONTROL;
  localparam logic [7:0] RHI = timer3_pkg::IDX_RELOAD_HIGH;
  localparam logic [7:0] RLO = timer3_pkg::IDX_RELOAD_LOW;
  localparam logic [7:0] LHI = timer3_pkg::IDX_LIVE_HIGH;
  localparam logic [7:0] LLO = timer3_pkg::IDX_LIVE_LOW;
  localparam logic [7:0] STA = timer3_pkg::IDX_IRQ_STATUS;
  localparam logic [7:0] MSK = timer3_pkg::IDX_IRQ_MASK;
  localparam logic [7:0] CMD = timer3_pkg::IDX_COMMAND;
  localparam logic [1:0] OK = timer3_pkg::RESP_OKAY;
  localparam logic [1:0] SE = timer3_pkg::RESP_SLVERR;
  typedef struct {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [1:0] wr_r;
    logic [1:0] rd_r;
  } row_t;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, osc, irq, ce;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, r;
  logic [3:0] ev, strb;
  logic [15:0] t2;
  logic [7:0] d;
  int fails, n_checks, cyc;
  row_t rows[8] = '{
    '{CTL, 8'hFF, 8'hBB, OK, OK},
    '{CTL, 8'h44, 8'h00, OK, OK},
    '{RHI, 8'hA5, 8'hA5, OK, OK},
    '{RLO, 8'h5A, 8'h5A, OK, OK},
    '{timer3_pkg::IDX_T2_LIVE_LOW, 8'h00, 8'h3C, SE, OK},
    '{LHI, 8'h77, 8'h00, SE, OK},
    '{MSK, 8'h01, 8'h01, OK, OK},
    '{8'h05, 8'h11, 8'h00, SE, SE}
  };

  reader_timer3_control u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(strb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .tx_end(ev[0]), .rx_first_nibble(ev[1]), .timer0_underflow(ev[2]),
    .timer1_underflow(ev[3]), .timer2_count(t2),
    .low_freq_oscillator(osc), .irq(irq)
  );

  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end

  // ********
  // tasks
  // ********
  task automatic err(input logic [15:0] g, input logic [15:0] e);
    fails++;
    $display("ERROR %0t got %h expected %h", $time, g, e);
  endtask
  task automatic chk_d(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) err(g, e);
  endtask
  task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
    n_checks++;
    if (g !== e) err(g, e);
  endtask
  task automatic chk_f(input logic g, input logic e);
    n_checks++;
    if (g !== e) err(g, e);
  endtask
  // tick counts drift with bus latency, so allow two either way
  task automatic chk_near(input logic [7:0] g, input int e);
    n_checks++;
    if ((g >= e - 2 && g <= e + 2) !== 1'h1) err(g, 16'(e));
  endtask
  task automatic do_reset;
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] dd);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, dd};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] idx);
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    r = rresp;
    d = rdata[7:0];
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
    rd(idx);
    chk_d(d, e);
  endtask
  // live counts read only with no frame arriving
  task automatic live(input logic [15:0] e);
    rchk(LHI, e[15:8]);
    rchk(LLO, e[7:0]);
  endtask
  task automatic tick(input int n, input int c);
    repeat (c) begin
      ev[n] <= 1'h1;
      @(posedge aclk);
      ev[n] <= 1'h0;
      @(posedge aclk);
    end
  endtask
  // oscillator passes a two-flop sync, so give it room
  task automatic osc_edge;
    osc <= 1'h0;
    repeat (5) @(posedge aclk);
    osc <= 1'h1;
    repeat (5) @(posedge aclk);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      wrap_up();
    end
  end

  // ********
  // sequence
  // ********
  initial begin
    aresetn = 1'h0;
    awvalid = 1'h0;
    wvalid = 1'h0;
    arvalid = 1'h0;
    bready = 1'h1;
    rready = 1'h1;
    awaddr = 10'h000;
    araddr = 10'h000;
    wdata = 32'h0;
    ev = 4'h0;
    osc = 1'h0;
    ce = 1'h1;
    strb = 4'h1;
    t2 = 16'hC33C;
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      chk_r(r, rows[i].wr_r);
      rd(rows[i].idx);
      chk_r(r, rows[i].rd_r);
      chk_d(d, rows[i].rd);
      chk_f(rdata[31:8] == 24'h00_0000, 1'h1);
    end
    do_reset();
    rchk(CTL, 8'h00);
    rchk(RHI, 8'h00);
    rchk(MSK, 8'h00);
    // lane 0 not strobed: answer okay, register untouched
    strb <= 4'h0;
    wr(RHI, 8'h33);
    chk_r(r, OK);
    strb <= 4'h1;
    rchk(RHI, 8'h00);
    t2 <= 16'hA55A;
    rchk(timer3_pkg::IDX_T2_LIVE_LOW, 8'h5A);
    wr(CTL, 8'h02);
    wr(RLO, 8'h03);
    wr(MSK, 8'h01);
    wr(CMD, 8'h01);
    live(16'h0003);
    tick(2, 2);
    live(16'h0001);
    tick(3, 1);
    live(16'h0001);
    wr(RLO, 8'h10);
    live(16'h0001);
    tick(2, 2);
    repeat (2) @(posedge aclk);
    chk_f(irq, 1'h1);
    rchk(STA, 8'h01);
    rchk(STA, 8'h00);
    chk_f(irq, 1'h0);
    tick(2, 2);
    rchk(STA, 8'h00);
    wr(CMD, 8'h01);
    live(16'h0010);
    wr(MSK, 8'h00);
    wr(CTL, 8'h0A);
    wr(RLO, 8'h01);
    wr(CMD, 8'h01);
    tick(2, 2);
    live(16'h0001);
    chk_f(irq, 1'h0);
    rchk(STA, 8'h01);
    wr(CTL, 8'h8A);
    tick(1, 1);
    tick(2, 1);
    live(16'h0001);
    wr(CTL, 8'h0A);
    wr(CMD, 8'h01);
    tick(1, 1);
    tick(2, 1);
    live(16'h0000);
    wr(CMD, 8'h02);
    wr(RLO, 8'h05);
    wr(CTL, 8'h12);
    tick(0, 1);
    live(16'h0005);
    wr(CMD, 8'h02);
    wr(CTL, 8'h02);
    wr(RLO, 8'h07);
    tick(0, 1);
    tick(2, 1);
    live(16'h0005);
    wr(CTL, 8'hA2);
    osc_edge();
    live(16'h0007);
    tick(1, 1);
    tick(2, 1);
    live(16'h0006);
    osc_edge();
    tick(2, 1);
    live(16'h0006);
    wr(RLO, 8'h01);
    osc_edge();
    tick(2, 2);
    rchk(STA, 8'h00);
    live(16'h0000);
    wr(CTL, 8'hB2);
    tick(2, 1);
    rchk(STA, 8'h01);
    // ticks while frozen must be lost; bus stays idle meanwhile
    wr(CTL, 8'h02);
    wr(RLO, 8'h04);
    wr(CMD, 8'h01);
    ce <= 1'h0;
    tick(2, 2);
    ce <= 1'h1;
    live(16'h0004);
    tick(2, 1);
    live(16'h0003);
    wr(CMD, 8'h02);
    wr(RHI, 8'hFF);
    wr(RLO, 8'hFF);
    wr(CTL, 8'h00);
    wr(CMD, 8'h01);
    repeat (2000) @(posedge aclk);
    rd(LLO);
    chk_near(8'hFF - d, 136);
    wr(CTL, 8'h01);
    wr(CMD, 8'h01);
    repeat (20000) @(posedge aclk);
    rd(LLO);
    chk_near(8'hFF - d, 21);
    wrap_up();
  end
endmodule
`default_nettype wire
